// ==== hdl/stb_pkg.sv ====
// constants and types for the strobe time base scaler
package stb_pkg;
	localparam int                  NUM_STROBES   = 4;
	localparam int                  COUNT_W       = 16;
	localparam int                  TB_W          = 8;
	localparam logic [11:0]         CTRL_OFFSET   = 12'h000;
	// field positions in hardware bit order, msb = quadlet bit 0
	localparam int                  PRESENT_BIT   = 31;
	localparam int                  DUR_LSB       = 8;
	localparam int                  DLY_LSB       = 0;
	localparam int                  DUR_LANE      = 1;
	localparam int                  DLY_LANE      = 0;
	localparam logic [TB_W-1:0]     TB_RESET      = 8'h01;
	localparam logic [TB_W-1:0]     TB_MIN        = 8'h01;
	localparam logic [TB_W-1:0]     TB_MAX        = 8'h55;
	// base unit 1/1024 ms made from the 100 MHz clock by fractional accumulation
	localparam int                  CLK_FREQ_HZ   = 100000000;
	localparam int                  UNITS_PER_MS  = 1024;
	localparam int                  CYCLES_PER_MS = CLK_FREQ_HZ / 1000;
	localparam int                  ACC_W         = 17;
	localparam logic [ACC_W-1:0]    ACC_STEP      = ACC_W'(UNITS_PER_MS);
	localparam logic [ACC_W-1:0]    ACC_WRAP      = ACC_W'(CYCLES_PER_MS);

	typedef enum logic [1:0] {
		STB_IDLE  = 2'b00,
		STB_DELAY = 2'b01,
		STB_PULSE = 2'b11
	} stb_state_t;

	typedef struct packed {
		logic [ACC_W-1:0]                   acc;
		logic                               base_tick;
		logic [TB_W-1:0]                    dly_tb;
		logic [TB_W-1:0]                    dur_tb;
		logic [31:0]                        prdata;
		logic                               pslverr;
		stb_state_t [NUM_STROBES-1:0]       st;
		logic [NUM_STROBES-1:0][TB_W-1:0]   sub;
		logic [NUM_STROBES-1:0][COUNT_W-1:0] cnt;
		logic [NUM_STROBES-1:0]             strobe;
	} stb_regs_t;
endpackage

// ==== hdl/stb_time_base.sv ====
// strobe time base control word with apb access and shared-time-base strobe timers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module stb_time_base
(
	input  wire logic                                      pclk,        // 100 mhz clock
	input  wire logic                                      presetn,     // async reset, active low
	input  wire logic                                      psel,        // apb select
	input  wire logic                                      penable,     // apb access phase
	input  wire logic                                      pwrite,      // apb write
	input  wire logic [11:0]                               paddr,       // apb byte address
	input  wire logic [31:0]                               pwdata,      // apb write data
	input  wire logic [3:0]                                pstrb,       // apb byte strobes
	output logic                                           pready,      // apb ready
	output logic [31:0]                                    prdata,      // apb read data
	output logic                                           pslverr,     // apb error, unmapped address
	input  wire logic [stb_pkg::NUM_STROBES-1:0]           strobe_trig, // per strobe start pulse
	input  wire logic [stb_pkg::NUM_STROBES-1:0][stb_pkg::COUNT_W-1:0] delay_count,    // per strobe delay value
	input  wire logic [stb_pkg::NUM_STROBES-1:0][stb_pkg::COUNT_W-1:0] duration_count, // per strobe duration value
	output logic [stb_pkg::NUM_STROBES-1:0]                strobe_out,  // strobe outputs
	output logic [stb_pkg::TB_W-1:0]                       delay_tb,    // current delay time base
	output logic [stb_pkg::TB_W-1:0]                       duration_tb  // current duration time base
);

	stb_pkg::stb_regs_t r;
	stb_pkg::stb_regs_t next_r;

	function automatic logic tb_ok(input logic [stb_pkg::TB_W-1:0] v);
		tb_ok = (v >= stb_pkg::TB_MIN) && (v <= stb_pkg::TB_MAX);
	endfunction

	// one unit further into the current time base
	function automatic logic [stb_pkg::TB_W-1:0] sub_step(input logic [stb_pkg::TB_W-1:0] sub);
		sub_step = sub + 8'h01;
	endfunction

	// test the advanced unit sub-counter; returns 1 when a full time base has elapsed
	// >= rather than == so a time base lowered mid-count still ends the unit
	function automatic logic unit_done(input logic [stb_pkg::TB_W-1:0] sub,
	                                   input logic [stb_pkg::TB_W-1:0] tb);
		unit_done = sub_step(sub) >= tb;
	endfunction

	// one count step down
	function automatic logic [stb_pkg::COUNT_W-1:0] count_down(input logic [stb_pkg::COUNT_W-1:0] c);
		count_down = c - 16'h0001;
	endfunction

	// count about to reach zero
	function automatic logic last_unit(input logic [stb_pkg::COUNT_W-1:0] c);
		last_unit = (c == 16'h0001);
	endfunction

	function automatic logic [31:0] ctrl_word(input logic [stb_pkg::TB_W-1:0] dly,
	                                          input logic [stb_pkg::TB_W-1:0] dur);
		ctrl_word                                       = 32'h0000_0000;
		ctrl_word[stb_pkg::PRESENT_BIT]                 = 1'b1;
		ctrl_word[stb_pkg::DUR_LSB +: stb_pkg::TB_W]    = dur;
		ctrl_word[stb_pkg::DLY_LSB +: stb_pkg::TB_W]    = dly;
	endfunction

	logic                        hit;
	logic                        setup;
	logic                        wr_access;
	logic [stb_pkg::TB_W-1:0]    wr_dur;
	logic [stb_pkg::TB_W-1:0]    wr_dly;
	logic                        take_dur;
	logic                        take_dly;

	assign hit       = (paddr[11:2] == stb_pkg::CTRL_OFFSET[11:2]);
	assign setup     = psel && !penable;
	// no gating by stream or video format state
	assign wr_access = psel && penable && pwrite && hit;
	assign wr_dur    = pwdata[stb_pkg::DUR_LSB +: stb_pkg::TB_W];
	assign wr_dly    = pwdata[stb_pkg::DLY_LSB +: stb_pkg::TB_W];
	// a field with its lane off or its value out of range keeps the old setting
	assign take_dur  = pstrb[stb_pkg::DUR_LANE] && tb_ok(wr_dur);
	assign take_dly  = pstrb[stb_pkg::DLY_LANE] && tb_ok(wr_dly);

	always_comb
	begin
		next_r = r;

		// 1/1024 ms base tick, exact on average
		// 100000 cycles per ms is no multiple of 1024, so ticks fall 97 or 98 cycles apart
		next_r.base_tick = 1'b0;
		if (r.acc + stb_pkg::ACC_STEP >= stb_pkg::ACC_WRAP)
		begin
			next_r.acc       = r.acc + stb_pkg::ACC_STEP - stb_pkg::ACC_WRAP;
			next_r.base_tick = 1'b1;
		end
		else
		begin
			next_r.acc = r.acc + stb_pkg::ACC_STEP;
		end

		// register write, out-of-range field values are ignored
		if (wr_access)
		begin
			if (take_dur)
			begin
				next_r.dur_tb = wr_dur;
			end
			if (take_dly)
			begin
				next_r.dly_tb = wr_dly;
			end
		end

		// read data and error prepared in setup phase
		if (setup)
		begin
			next_r.pslverr = !hit;
			next_r.prdata  = (hit && !pwrite) ? ctrl_word(r.dly_tb, r.dur_tb) : 32'h0000_0000;
		end

		for (int i = 0; i < stb_pkg::NUM_STROBES; i++)
		begin
			case (r.st[i])
				stb_pkg::STB_IDLE:
				begin
					next_r.strobe[i] = 1'b0;
					next_r.sub[i]    = '0;
					// triggers outside idle are dropped
					if (strobe_trig[i])
					begin
						if (delay_count[i] != '0)
						begin
							next_r.st[i]  = stb_pkg::STB_DELAY;
							next_r.cnt[i] = delay_count[i];
						end
						else if (duration_count[i] != '0)
						begin
							next_r.st[i]     = stb_pkg::STB_PULSE;
							next_r.cnt[i]    = duration_count[i];
							next_r.strobe[i] = 1'b1;
						end
					end
				end
				stb_pkg::STB_DELAY:
				begin
					if (r.base_tick)
					begin
						// shared delay time base
						if (unit_done(r.sub[i], r.dly_tb))
						begin
							next_r.sub[i] = '0;
							next_r.cnt[i] = count_down(r.cnt[i]);
							if (last_unit(r.cnt[i]))
							begin
								if (duration_count[i] != '0)
								begin
									next_r.st[i]     = stb_pkg::STB_PULSE;
									next_r.cnt[i]    = duration_count[i];
									next_r.strobe[i] = 1'b1;
								end
								// zero duration: no pulse
								else
								begin
									next_r.st[i] = stb_pkg::STB_IDLE;
								end
							end
						end
						else
						begin
							next_r.sub[i] = sub_step(r.sub[i]);
						end
					end
				end
				stb_pkg::STB_PULSE:
				begin
					if (r.base_tick)
					begin
						// shared duration time base
						if (unit_done(r.sub[i], r.dur_tb))
						begin
							next_r.sub[i] = '0;
							next_r.cnt[i] = count_down(r.cnt[i]);
							if (last_unit(r.cnt[i]))
							begin
								next_r.st[i]     = stb_pkg::STB_IDLE;
								next_r.strobe[i] = 1'b0;
							end
						end
						else
						begin
							next_r.sub[i] = sub_step(r.sub[i]);
						end
					end
				end
				default:
				begin
					next_r.st[i]     = stb_pkg::STB_IDLE;
					next_r.strobe[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// all zero leaves every strobe channel idle
			r           <= '0;
			r.dly_tb    <= stb_pkg::TB_RESET;
			r.dur_tb    <= stb_pkg::TB_RESET;
		end
		else
		begin
			r <= next_r;
		end
	end

	// read data and error stand from the setup edge, so no wait states
	assign pready      = 1'b1;
	assign prdata      = r.prdata;
	assign pslverr     = r.pslverr;
	assign strobe_out  = r.strobe;
	assign delay_tb    = r.dly_tb;
	assign duration_tb = r.dur_tb;

endmodule
`default_nettype wire

// ==== verification/stb_checker.sv ====
// assertions on the control word ports
`timescale 1ns/1ps
`default_nettype none
module stb_checker
(
	input	wire logic		pclk,		// clock
	input	wire logic		presetn,	// reset
	input	wire logic		psel,		// select
	input	wire logic		penable,	// access
	input	wire logic		pwrite,		// write
	input	wire logic [11:0]	paddr,		// address
	input	wire logic [31:0]	pwdata,		// wdata
	input	wire logic [3:0]	pstrb,		// strobes
	input	wire logic		pready,		// ready
	input	wire logic [31:0]	prdata,		// rdata
	input	wire logic		pslverr,	// error
	input	wire logic [7:0]	delay_tb,	// delay base
	input	wire logic [7:0]	duration_tb	// duration base
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire	acc = psel & penable & (paddr[11:2] == 10'h0);
	wire	wr = acc & pwrite;
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_dly_rng; delay_tb >= 8'h01 && delay_tb <= 8'h55; endproperty
	a_dly_rng: assert property (p_dly_rng) else $error("delay base out of range");
	property p_dur_rng; duration_tb >= 8'h01 && duration_tb <= 8'h55; endproperty
	a_dur_rng: assert property (p_dur_rng) else $error("duration base out of range");
	property p_dly_wr; wr && pstrb[0] && pwdata[7:0] inside {[8'h01:8'h55]} |=> delay_tb == $past(pwdata[7:0]); endproperty
	a_dly_wr: assert property (p_dly_wr) else $error("delay base not written");
	property p_dur_wr; wr && pstrb[1] && pwdata[15:8] inside {[8'h01:8'h55]} |=> duration_tb == $past(pwdata[15:8]); endproperty
	a_dur_wr: assert property (p_dur_wr) else $error("duration base not written");
	property p_dly_keep; !(wr && pstrb[0]) |=> $stable(delay_tb); endproperty
	a_dly_keep: assert property (p_dly_keep) else $error("delay base moved");
	property p_dur_keep; !(wr && pstrb[1]) |=> $stable(duration_tb); endproperty
	a_dur_keep: assert property (p_dur_keep) else $error("duration base moved");
	property p_read; acc && !pwrite |-> prdata == {1'b1, 15'h0, duration_tb, delay_tb} && !pslverr; endproperty
	a_read: assert property (p_read) else $error("control word read wrong");
endmodule
bind stb_time_base stb_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .delay_tb(delay_tb), .duration_tb(duration_tb));
`default_nettype wire

// ==== verification/stb_light_model.sv ====
// lamp model: logs strobe edge cycles
`timescale 1ns/1ps
`default_nettype none
module stb_light_model
(
	input	wire logic		pclk,		// clock
	input	wire logic [3:0]	strobe_out	// strobe lines
);
	int	cyc = 0;
	int	rise_at [4];
	int	fall_at [4];
	logic [3:0]	last = 4'h0;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		last <= strobe_out;
		for (int i = 0; i < 4; i++)
		begin
			if (strobe_out[i] & !last[i]) rise_at[i] <= cyc;
			if (!strobe_out[i] & last[i]) fall_at[i] <= cyc;
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb_strobe_time_base_scaler.sv ====
// self-checking bench for the strobe time base scaler
`timescale 1ns/1ps
`default_nettype none
module tb_strobe_time_base_scaler;
	logic	pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0]	paddr = 12'h0;
	logic [31:0]	pwdata = 32'h0, prdata, rd;
	logic [3:0]	pstrb = 4'h0, trig = 4'h0, strobe_out, st;
	logic [3:0][15:0]	dcnt = '0, ucnt = '0;
	logic [7:0]	delay_tb, duration_tb, vd, vu, xd = 8'h01, xu = 8'h01;
	int	n_errors = 0, check_count = 0, t0;
	localparam logic [7:0] corner [4] = '{8'h00, 8'h56, 8'h55, 8'h01};
	stb_time_base dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.strobe_trig(trig), .delay_count(dcnt), .duration_count(ucnt), .strobe_out(strobe_out),
		.delay_tb(delay_tb), .duration_tb(duration_tb));
	stb_light_model lamp (.pclk(pclk), .strobe_out(strobe_out));
	initial forever #5 pclk = ~pclk;
	function automatic logic [7:0] nxt(input logic [7:0] o, input logic [7:0] v, input logic en);
		return (en && v >= 8'h01 && v <= 8'h55) ? v : o;
	endfunction
	function automatic logic near(input int a, input int b);
		return (a - b <= 110) && (b - a <= 110);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n = 0;
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		if (pready !== 1'b1)
			n_errors++;
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#300000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(32'h667d));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk(rd, 32'h8000_0101);
		apb(1'b1, 12'h004, 32'h0000_0707, 4'h3);
		chk(32'(err), 32'h1);
		for (int k = 0; k < 24; k++)
		begin
			vd = k < 4 ? corner[k] : 8'($urandom_range(0, 100));
			vu = k < 4 ? corner[3 - k] : 8'($urandom_range(0, 100));
			st = k < 4 ? 4'h3 : 4'($urandom);
			apb(1'b1, 12'h000, {16'($urandom), vu, vd}, st);
			xd = nxt(xd, vd, st[0]);
			xu = nxt(xu, vu, st[1]);
			apb(1'b0, 12'h000, 32'h0, 4'h0);
			chk({16'h0, duration_tb, delay_tb}, {16'h0, xu, xd});
			chk(rd, {1'b1, 15'h0, xu, xd});
		end
		apb(1'b1, 12'h000, 32'h0000_0302, 4'h3);
		for (int i = 0; i < 4; i++)
			{dcnt[i], ucnt[i]} <= {16'(i), 16'(2 * i + 1)};
		@(posedge pclk) trig <= 4'hf;
		@(posedge pclk) trig <= 4'h0;
		t0 = lamp.cyc;
		repeat (3500) @(posedge pclk);
		for (int i = 0; i < 4; i++)
		begin
			chk(32'(near(lamp.rise_at[i] - t0, i * 2 * 100000 / 1024)), 32'h1);
			chk(32'(near(lamp.fall_at[i] - lamp.rise_at[i], (2 * i + 1) * 3 * 100000 / 1024)), 32'h1);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
